// >>> hdl/edge_line_cfg.svh
/*
 Register offsets, field layout and reset values of the edge line controller.
 Assumes inclusion by bare name from the package and the top module.
*/
`ifndef EDGE_LINE_CFG_SVH
`define EDGE_LINE_CFG_SVH

`define ELC_NUM_LINES       26
`define ELC_NUM_PIN_LINES   16
`define ELC_NUM_INT_LINES   10
`define ELC_ADDR_W          8
`define ELC_DATA_W          32
`define ELC_OFS_IRQ_EN      8'h00
`define ELC_OFS_EVT_EN      8'h04
`define ELC_OFS_RISE_EN     8'h08
`define ELC_OFS_FALL_EN     8'h0c
`define ELC_OFS_SOFT_TRIG   8'h10
`define ELC_OFS_PENDING     8'h14
`define ELC_RESET_VALUE     26'h0000000
`define ELC_PENDING_RESET   26'h0000000
`define ELC_UNMAPPED_READ   32'h00000000

`endif

// >>> hdl/edge_line_controller.sv
/*
 Edge line controller: 26 edge-detecting lines raising interrupt requests,
 event pulses and a wakeup request, programmed through six word registers.
 Assumes line inputs synchronous to clk, and software using whole-word
 accesses that write the upper bits as zero.
*/
// Decided for this implementation: strobed register access.
// Notes on behaviour
// R1: Twenty-six lines, each configured and masked on its own.
// R2: Each line triggers on rising, falling, or both edges.
// R3: Lines 0 to 15 come from pins, 16 to 25 from internal sources.
// R4: Pin line n takes pin n of the externally selected port.
// R5: Internal lines: voltage detect, alarm, USB, Ethernet, tamper, wakeup, I2C.
// R6: Event signals are delivered besides interrupts, selectable per line.
// R7: An enabled trigger can wake the processor and system.
// R8: Rising enable 0 ignores rising edges; 1 makes them requests.
// R9: Falling enable 1 makes falling edges requests; 0 ignores them.
// R10: Both enables set together detect changes in both directions.
// R11: Interrupt request forwarded only while the interrupt enable is 1.
// R12: Event generated only while the event enable is 1.
// R13: An enabled edge sets the line's pending flag.
// R14: Writing 1 to software trigger sets pending at once; 0 deactivates. Here only a 0-to-1 of the bit sets pending.
// R15: Writing 1 to a pending bit clears it; 0 leaves it.
// R16: Pending flags undefined after reset; all other registers reset to zero.
// R17: Software uses only full 32-bit word accesses.
// R18: Software writes bits 31 to 26 as zero.
// R19: Software selects sources, edges, then enables; clears pending after service.
// R20: Interrupt request is pending AND interrupt enable, held until cleared.
// R21: Edges compare input with previous cycle; events are one-cycle pulses.
`timescale 1ns/1ns

`include "edge_line_cfg.svh"

module edge_line_controller
    import edge_line_pkg::*;
#(
    parameter int NUM_LINES     = `ELC_NUM_LINES,
    parameter int NUM_PIN_LINES = `ELC_NUM_PIN_LINES
)
(
    input  wire logic                   clk,          // Bus clock, 100 MHz
    input  wire logic                   rst,          // Async reset, active high
    input  wire logic [`ELC_ADDR_W-1:0] reg_addr,     // Register byte address
    input  wire logic [`ELC_DATA_W-1:0] reg_wdata,    // Write data
    input  wire logic                   reg_wr,       // Write strobe
    input  wire logic                   reg_rd,       // Read strobe
    output logic      [`ELC_DATA_W-1:0] reg_rdata,    // Read data, cycle after strobe
    input  wire logic [15:0]            pin_lines,    // Selected port pins, line n = pin n
    input  wire logic                   low_voltage_detect, // Line 16
    input  wire logic                   clk_alarm,    // Line 17
    input  wire logic                   usb_fs_wakeup, // Line 18
    input  wire logic                   eth_wakeup,   // Line 19
    input  wire logic                   usb_hs_wakeup, // Line 20
    input  wire logic                   clk_tamper,   // Line 21, tamper or timestamp
    input  wire logic                   clk_wakeup,   // Line 22
    input  wire logic [2:0]             i2c_wakeup,   // Lines 23 to 25
    output line_vec_t                   line_irq,     // Per-line interrupt request
    output line_vec_t                   line_evt,     // Per-line event pulse
    output logic                        any_irq,      // Any interrupt request standing
    output logic                        evt_pulse,    // Any event, one cycle
    output logic                        wakeup_req    // Wake request to wakeup_irq_ctrl
);

    // The logic is written for the documented line split only
    if (NUM_LINES != `ELC_NUM_LINES || NUM_PIN_LINES != `ELC_NUM_PIN_LINES)
    begin : g_bad_line_count
        $error("edge_line_controller: unsupported line count");
    end

    // Address decode shared by the write and read paths
    function automatic reg_sel_e decode(input logic [`ELC_ADDR_W-1:0] a);
        case (a)
            `ELC_OFS_IRQ_EN:    decode = REG_IRQ_EN;
            `ELC_OFS_EVT_EN:    decode = REG_EVT_EN;
            `ELC_OFS_RISE_EN:   decode = REG_RISE_EN;
            `ELC_OFS_FALL_EN:   decode = REG_FALL_EN;
            `ELC_OFS_SOFT_TRIG: decode = REG_SOFT_TRIG;
            `ELC_OFS_PENDING:   decode = REG_PENDING;
            default:            decode = REG_NONE;
        endcase
    endfunction

    // Zero-extend a line vector onto the data bus
    function automatic logic [`ELC_DATA_W-1:0] widen(input line_vec_t v);
        widen = {{(`ELC_DATA_W-`ELC_NUM_LINES){1'b0}}, v};
    endfunction

    reg_req_s  req;
    reg_sel_e  sel;
    line_vec_t line_in;
    line_vec_t line_prev;
    line_vec_t irq_en;
    line_vec_t evt_en;
    line_vec_t rise_en;
    line_vec_t fall_en;
    line_vec_t soft_trig;
    line_vec_t pending;
    line_vec_t rise_edge;
    line_vec_t fall_edge;
    line_vec_t hw_trig;
    line_vec_t sw_set;
    line_vec_t trig;
    line_vec_t wr_bits;
    line_vec_t next_pending;
    logic      prev_valid;

    assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};
    assign sel = decode(req.addr);
    // Bits 31:26 are dropped on write; software keeps them zero [R18]
    assign wr_bits = req.wdata[`ELC_NUM_LINES-1:0]; // Full-word writes only [R17]

    // Gather line inputs: pins low, internal sources above [R3] [R4] [R5]
    assign line_in = {i2c_wakeup, clk_wakeup, clk_tamper, usb_hs_wakeup,
                      eth_wakeup, usb_fs_wakeup, clk_alarm, low_voltage_detect,
                      pin_lines};

    // Previous-cycle copy of every line; first cycle after reset is not an edge
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            line_prev  <= `ELC_RESET_VALUE;
            prev_valid <= 1'b0;
        end
        else
        begin
            line_prev  <= line_in;             // [R21]
            prev_valid <= 1'b1;
        end
    end

    // Edge detection, each line gated by its own enables [R1] [R2]
    assign rise_edge = line_in & ~line_prev & {NUM_LINES{prev_valid}};  // [R21]
    assign fall_edge = ~line_in & line_prev & {NUM_LINES{prev_valid}};  // [R21]
    // Both enables set give both directions [R10]
    assign hw_trig   = (rise_edge & rise_en) | (fall_edge & fall_en);   // [R8] [R9]

    // Software trigger sets pending at once on a 0-to-1 of its bit
    assign sw_set = (sel == REG_SOFT_TRIG && req.wr) ? (wr_bits & ~soft_trig)
                                                     : `ELC_RESET_VALUE;   // [R14]
    assign trig   = hw_trig | sw_set;

    // Configuration registers, all zero after reset [R16]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            irq_en  <= `ELC_RESET_VALUE;
            evt_en  <= `ELC_RESET_VALUE;
            rise_en <= `ELC_RESET_VALUE;
            fall_en <= `ELC_RESET_VALUE;
        end
        else if (req.wr)
        begin
            case (sel)
                REG_IRQ_EN:  irq_en  <= wr_bits;
                REG_EVT_EN:  evt_en  <= wr_bits;
                REG_RISE_EN: rise_en <= wr_bits;
                REG_FALL_EN: fall_en <= wr_bits;
                default:     irq_en  <= irq_en;
            endcase
        end
    end

    // Software trigger bits; writing 0 deactivates the request [R14] [R16]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            soft_trig <= `ELC_RESET_VALUE;
        end
        else if (req.wr && sel == REG_SOFT_TRIG)
        begin
            soft_trig <= wr_bits;
        end
    end

    // Pending flags: set on trigger, write 1 clears, set wins over clear
    always_comb
    begin
        next_pending = pending;
        if (req.wr && sel == REG_PENDING)
        begin
            next_pending = next_pending & ~wr_bits;           // [R15]
        end
        next_pending = next_pending | trig;                  // [R13]
    end

    // Pending is undefined by spec; cleared here so no stray request at start
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            pending <= `ELC_PENDING_RESET;                    // [R16]
        end
        else
        begin
            pending <= next_pending;
        end
    end

    // Level interrupt requests held until pending is cleared [R11] [R20]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            line_irq <= `ELC_RESET_VALUE;
            any_irq  <= 1'b0;
        end
        else
        begin
            line_irq <= next_pending & irq_en;                // [R20]
            any_irq  <= |(next_pending & irq_en);             // [R11]
        end
    end

    // Event pulses: one cycle per trigger, per-line selectable [R6] [R12]
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            line_evt  <= `ELC_RESET_VALUE;
            evt_pulse <= 1'b0;
        end
        else
        begin
            line_evt  <= trig & evt_en;                       // [R21]
            evt_pulse <= |(trig & evt_en);                    // [R12]
        end
    end

    // Wake request on any enabled interrupt or event; registered on the clk edge like the other outputs
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            wakeup_req <= 1'b0;
        end
        else
        begin
            wakeup_req <= |((next_pending & irq_en) | (trig & evt_en)); // [R7]
        end
    end

    // Read data one cycle after the strobe, zero otherwise and for holes
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
        begin
            reg_rdata <= `ELC_UNMAPPED_READ;
        end
        else if (req.rd)
        begin
            case (sel)
                REG_IRQ_EN:    reg_rdata <= widen(irq_en);
                REG_EVT_EN:    reg_rdata <= widen(evt_en);
                REG_RISE_EN:   reg_rdata <= widen(rise_en);
                REG_FALL_EN:   reg_rdata <= widen(fall_en);
                REG_SOFT_TRIG: reg_rdata <= widen(soft_trig);
                REG_PENDING:   reg_rdata <= widen(pending);
                default:       reg_rdata <= `ELC_UNMAPPED_READ;
            endcase
        end
        else
        begin
            reg_rdata <= `ELC_UNMAPPED_READ;
        end
    end

endmodule // edge_line_controller

// >>> hdl/edge_line_pkg.sv
/*
 Types shared by the edge line controller and its bench.
 Assumes edge_line_cfg.svh is on the include path.
*/
`include "edge_line_cfg.svh"

package edge_line_pkg;

    typedef logic [`ELC_NUM_LINES-1:0] line_vec_t;

    // One register bus request from software
    typedef struct packed {
        logic [`ELC_ADDR_W-1:0] addr;
        logic [`ELC_DATA_W-1:0] wdata;
        logic                   wr;
        logic                   rd;
    } reg_req_s;

    // Register selected by a decoded address
    typedef enum logic [2:0] {
        REG_IRQ_EN    = 3'b000,
        REG_EVT_EN    = 3'b001,
        REG_RISE_EN   = 3'b010,
        REG_FALL_EN   = 3'b011,
        REG_SOFT_TRIG = 3'b100,
        REG_PENDING   = 3'b101,
        REG_NONE      = 3'b111
    } reg_sel_e;

endpackage

// >>> test/core_wake_model.sv
/*
 Core wakeup side: counts events, wakes on request.
 Assumes inputs synchronous to clk.
*/
`timescale 1ns/1ns

module core_wake_model
(
    input  wire logic       clk,        // Bus clock
    input  wire logic       rst,        // Async reset
    input  wire logic       evt_pulse,  // Event pulse
    input  wire logic       wakeup_req, // Wake request
    output logic      [7:0] evt_count,  // Events seen
    output logic            awake       // Woken since reset
);
    // Pulses counted, so a stretched pulse shows as extra events
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            {evt_count, awake} <= 9'h0;
        else
            {evt_count, awake} <= {evt_count + {7'h0, evt_pulse}, awake | wakeup_req};
    end
endmodule // core_wake_model

// >>> test/edge_line_monitor.sv
/*
 Port checker for the edge line controller.
 Assumes binding to every edge_line_controller instance.
*/
`timescale 1ns/1ns

module edge_line_monitor
    import edge_line_pkg::*;
(
    input wire logic        clk,        // Bus clock
    input wire logic        rst,        // Async reset
    input wire logic [7:0]  reg_addr,   // Address
    input wire logic [31:0] reg_wdata,  // Write data
    input wire logic        reg_wr,     // Write strobe
    input wire logic [15:0] pin_lines,  // Pin lines
    input wire line_vec_t   line_irq,   // Line requests
    input wire line_vec_t   line_evt,   // Line events
    input wire logic        any_irq,    // Any request
    input wire logic        evt_pulse,  // Any event
    input wire logic        wakeup_req  // Wake request
);
    logic evt_sh;
    logic rise_sh;
    logic fall_sh;

    // Line 0 enables, mirrored so edges can be judged
    always_ff @(posedge clk or posedge rst)
    begin
        if (rst)
            {evt_sh, rise_sh, fall_sh} <= 3'h0;
        else if (reg_wr && reg_addr == 8'h04)
            evt_sh <= reg_wdata[0];
        else if (reg_wr && reg_addr == 8'h08)
            rise_sh <= reg_wdata[0];
        else if (reg_wr && reg_addr == 8'h0c)
            fall_sh <= reg_wdata[0];
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    irq_or_a: assert property (any_irq == |line_irq)
        else $error("any_irq differs from line requests");
    wake_or_a: assert property (wakeup_req == (any_irq || evt_pulse))
        else $error("wake request wrong");
    evt_or_a: assert property (evt_pulse == |line_evt)
        else $error("evt_pulse differs from line events");
    rise_evt_a: assert property ($rose(pin_lines[0]) && rise_sh && evt_sh |=> line_evt[0])
        else $error("rising edge lost");
    fall_off_a: assert property ($fell(pin_lines[0]) && !fall_sh && !reg_wr |=> !line_evt[0])
        else $error("disabled falling edge seen");
    evt_mask_a: assert property (!evt_sh && !$past(evt_sh) |-> !line_evt[0])
        else $error("event while disabled");
    evt_once_a: assert property (line_evt[0] && $stable(pin_lines[0]) && !reg_wr |=> !line_evt[0])
        else $error("event longer than one cycle");
    irq_hold_a: assert property (line_irq[0] && !reg_wr && !$past(reg_wr) |=> line_irq[0])
        else $error("request dropped uncleared");
endmodule // edge_line_monitor

bind edge_line_controller edge_line_monitor edge_line_monitor_inst (
    .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .pin_lines(pin_lines), .line_irq(line_irq), .line_evt(line_evt), .any_irq(any_irq),
    .evt_pulse(evt_pulse), .wakeup_req(wakeup_req));

// >>> test/testbench.sv
/*
 Self-checking bench for the edge line controller.
 Assumes package, checker and core model compiled first.
*/
`timescale 1ns/1ns

module testbench
    import edge_line_pkg::*;
;
    logic        clk, rst, reg_wr, reg_rd, any_irq, evt_pulse, wakeup_req, awake;
    logic [7:0]  reg_addr, evt_count;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] pin_in;
    logic [9:0]  int_in;
    line_vec_t   line_irq, line_evt;
    int          n_mismatch, num_checks;

    edge_line_controller edge_line_controller_inst (
        .clk(clk), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .pin_lines(pin_in),
        .low_voltage_detect(int_in[0]), .clk_alarm(int_in[1]), .usb_fs_wakeup(int_in[2]),
        .eth_wakeup(int_in[3]), .usb_hs_wakeup(int_in[4]), .clk_tamper(int_in[5]),
        .clk_wakeup(int_in[6]), .i2c_wakeup(int_in[9:7]), .line_irq(line_irq),
        .line_evt(line_evt), .any_irq(any_irq), .evt_pulse(evt_pulse),
        .wakeup_req(wakeup_req));

    core_wake_model core_wake_model_inst (.clk(clk), .rst(rst), .evt_pulse(evt_pulse),
        .wakeup_req(wakeup_req), .evt_count(evt_count), .awake(awake));

    // 100 MHz clock
    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // Hang guard, far past the hundred or so cycles needed
    initial
    begin
        #100000;
        n_mismatch++;
        conclude();
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("ERROR t=%0t seen %h want %h", $time, seen, exp);
        end
    endtask

    // Whole-word bus cycles, upper bits always zero
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        {reg_rd, reg_addr} <= {1'b1, a};
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask

    // Drive lines, then let detection settle
    task automatic lines(input logic [15:0] p, input logic [9:0] i);
        @(posedge clk);
        {pin_in, int_in} <= {p, i};
        repeat (3) @(posedge clk);
    endtask

    // Reset values, read-back, unmapped place
    task automatic t_regs();
        for (int i = 0; i < 6; i++)
            rd(8'(i * 4), 32'h0);
        for (int i = 0; i < 4; i++)
        begin
            wr(8'(i * 4), 32'h02a5_5a5a);
            rd(8'(i * 4), 32'h02a5_5a5a);
        end
        rd(8'h18, 32'h0);
    endtask

    // Pins then internal lines, masked requests, partial clear, falls
    task automatic t_edges();
        wr(8'h08, 32'h03ff_ffff);
        wr(8'h0c, 32'h0000_0004);
        wr(8'h04, 32'h03ff_ffff);
        wr(8'h00, 32'h0000_0001);
        lines(16'hffff, 10'h0);
        rd(8'h14, 32'h0000_ffff);
        lines(16'hffff, 10'h3ff);
        rd(8'h14, 32'h03ff_ffff);
        chk(32'(line_irq), 32'h1);
        wr(8'h14, 32'h03ff_fffe);
        rd(8'h14, 32'h0000_0001);
        chk(32'(line_irq), 32'h1);
        lines(16'h0, 10'h0);
        rd(8'h14, 32'h0000_0005);
        wr(8'h14, 32'h03ff_ffff);
        rd(8'h14, 32'h0);
        chk({31'h0, any_irq}, 32'h0);
    endtask

    // Software trigger with events off
    task automatic t_soft();
        wr(8'h04, 32'h0);
        wr(8'h08, 32'h0);
        lines(16'h0002, 10'h0);
        rd(8'h14, 32'h0);
        wr(8'h00, 32'h0200_0000);
        wr(8'h10, 32'h0200_0000);
        #1 chk(32'(line_irq), 32'h0200_0000);
        rd(8'h10, 32'h0200_0000);
        wr(8'h10, 32'h0);
        wr(8'h14, 32'h0200_0000);
        rd(8'h14, 32'h0);
        chk({24'h0, evt_count}, 32'h3);
        chk({31'h0, awake}, 32'h1);
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask

    // Reset, then the scenarios
    initial
    begin
        {rst, reg_wr, reg_rd, reg_addr, reg_wdata} = {3'b100, 40'h0};
        {pin_in, int_in} = 26'h0;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        t_regs();
        t_edges();
        t_soft();
        conclude();
    end
endmodule // testbench
